// ### scpm_pkg.sv
// Function
// - Register at offset 20h, resets to zero
// - Bits 31 to 26 read zero
// - Bit 25 sets on any card access
// - A register read clears bit 25, unless a card access comes in the same cycle
// - Bit 24 shows clock changed from normal
// - Bits 23 to 17 read zero
// - Bit 16 gates the bit 0 selection
// - Bit 16 resets to zero, control disabled
// - Bits 15 to 1 read zero
// - Bit 0 clear: idle may stop clock
// - Bit 0 enabled: idle slows clock sixteenfold
package scpm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h20;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    localparam int ACCESS_BIT = 25;
    localparam int CHANGED_BIT = 24;
    localparam int UNLOCK_BIT = 16;
    localparam int SELECT_BIT = 0;

    // Byte lane that carries each writable bit
    localparam int UNLOCK_LANE = 2;
    localparam int SELECT_LANE = 0;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Card clock generation
    // ------------------------------------------------------------
    // Both source edges are counted, so 16 edges per output half period
    localparam int SLOW_CNT_W = 4;
    localparam logic [SLOW_CNT_W-1:0] SLOW_CNT_ZERO = 4'h0;
    localparam logic [SLOW_CNT_W-1:0] SLOW_CNT_LAST = 4'hf;
    localparam logic [SLOW_CNT_W-1:0] SLOW_CNT_STEP = 4'h1;

    typedef enum logic [1:0] {
        SCPM_NORMAL = 2'b00,
        SCPM_SLOW = 2'b01,
        SCPM_STOPPED = 2'b10
    } scpm_mode_t;

endpackage

// ### scpm_sync.sv
module scpm_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // scpm_sync

// ### scpm_top.sv
module scpm_top (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [scpm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [scpm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Socket side
    input wire logic card_clk_src,
    input wire logic socket_idle,
    input wire logic card_access_pulse,
    output logic card_clk,
    output logic clock_changed_status
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_full_q;
    logic [scpm_pkg::ADDR_W-1:0] aw_addr_q;
    logic w_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_commit;
    logic wr_hit;
    logic rd_hit;
    logic rd_clear;
    logic unlock_wr_en;
    logic select_wr_en;

    logic card_access_seen_q;
    logic card_access_seen_d;
    logic clock_policy_unlock_q;
    logic slow_not_stop_select_q;
    logic clock_changed_status_q;
    logic [31:0] reg_value;

    logic src_sync;
    logic idle_sync;
    logic src_prev_q;
    logic src_edge;
    logic policy_slow;
    scpm_pkg::scpm_mode_t mode_q;
    scpm_pkg::scpm_mode_t mode_target;
    logic [scpm_pkg::SLOW_CNT_W-1:0] slow_cnt_q;
    logic card_clk_q;
    logic mode_switch;
    logic slow_wrap;

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    // Address and data are parked separately so they may come in either order
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign wr_commit = aw_full_q && w_full_q && !bvalid_q;

    // Word aligned decode, byte offset bits ignored
    assign wr_hit = (aw_addr_q[scpm_pkg::ADDR_W-1:2] == scpm_pkg::REG_OFFSET[scpm_pkg::ADDR_W-1:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_commit) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_commit) begin
            w_full_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------
    // Answer waits for both halves, so a lone address never answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= scpm_pkg::RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? scpm_pkg::RESP_OKAY : scpm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------
    // Read channels
    // ------------------------------------------------------------
    // One read in flight; a new address waits until the data is taken
    assign s_axi_arready = !rvalid_q;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_hit = (s_axi_araddr[scpm_pkg::ADDR_W-1:2] == scpm_pkg::REG_OFFSET[scpm_pkg::ADDR_W-1:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= scpm_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? reg_value : '0;
            rresp_q <= rd_hit ? scpm_pkg::RESP_OKAY : scpm_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------
    // Reserved bits stay zero because only four bits are ever placed
    always_comb begin
        reg_value = scpm_pkg::REG_RESET;
        reg_value[scpm_pkg::ACCESS_BIT] = card_access_seen_q;
        reg_value[scpm_pkg::CHANGED_BIT] = clock_changed_status_q;
        reg_value[scpm_pkg::UNLOCK_BIT] = clock_policy_unlock_q;
        reg_value[scpm_pkg::SELECT_BIT] = slow_not_stop_select_q;
    end

    // A hit on the register clears the flag; a miss leaves it standing
    assign rd_clear = ar_hs && rd_hit;

    // Read value is captured before the clear, and a new access wins
    always_comb begin
        card_access_seen_d = card_access_seen_q;
        if (rd_clear) begin
            card_access_seen_d = 1'b0;
        end
        if (card_access_pulse) begin
            card_access_seen_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_access_seen_q <= scpm_pkg::REG_RESET[scpm_pkg::ACCESS_BIT];
        end else begin
            card_access_seen_q <= card_access_seen_d;
        end
    end

    // ------------------------------------------------------------
    // Writable bits
    // ------------------------------------------------------------
    // Each stored bit follows its own byte lane strobe
    assign unlock_wr_en = wr_commit && wr_hit && w_strb_q[scpm_pkg::UNLOCK_LANE];
    assign select_wr_en = wr_commit && wr_hit && w_strb_q[scpm_pkg::SELECT_LANE];

    // Status bits and reserved bits ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_policy_unlock_q <= scpm_pkg::REG_RESET[scpm_pkg::UNLOCK_BIT];
        end else if (unlock_wr_en) begin
            clock_policy_unlock_q <= w_data_q[scpm_pkg::UNLOCK_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_not_stop_select_q <= scpm_pkg::REG_RESET[scpm_pkg::SELECT_BIT];
        end else if (select_wr_en) begin
            slow_not_stop_select_q <= w_data_q[scpm_pkg::SELECT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Clock mode status
    // ------------------------------------------------------------
    // Lags the mode register by one cycle; a read sees the settled mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_changed_status_q <= scpm_pkg::REG_RESET[scpm_pkg::CHANGED_BIT];
        end else begin
            clock_changed_status_q <= (mode_q != scpm_pkg::SCPM_NORMAL);
        end
    end

    assign clock_changed_status = clock_changed_status_q;

    // ------------------------------------------------------------
    // Socket inputs
    // ------------------------------------------------------------
    scpm_sync u_src_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(card_clk_src),
        .sync_out(src_sync)
    );

    scpm_sync u_idle_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(socket_idle),
        .sync_out(idle_sync)
    );

    // ------------------------------------------------------------
    // Source edge detect
    // ------------------------------------------------------------
    // Reads only the second stage, never the metastable first one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_sync;
        end
    end

    // Either edge of the source clock
    assign src_edge = src_sync ^ src_prev_q;

    // ------------------------------------------------------------
    // Clock policy
    // ------------------------------------------------------------
    // Selection only counts while unlocked; otherwise idle means stop
    assign policy_slow = clock_policy_unlock_q && slow_not_stop_select_q;

    // A card access in progress keeps the clock running
    always_comb begin
        if (!idle_sync || card_access_pulse) begin
            mode_target = scpm_pkg::SCPM_NORMAL;
        end else if (policy_slow) begin
            mode_target = scpm_pkg::SCPM_SLOW;
        end else begin
            mode_target = scpm_pkg::SCPM_STOPPED;
        end
    end

    // ------------------------------------------------------------
    // Card clock generator
    // ------------------------------------------------------------
    // Mode changes only while the output is low, so no runt pulse
    // reaches the card; the cost is up to one output period of delay.
    assign mode_switch = src_edge && !card_clk_q && (mode_target != mode_q);
    assign slow_wrap = (slow_cnt_q == scpm_pkg::SLOW_CNT_LAST);

    // An illegal code never matches the target, so the next switch repairs it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= scpm_pkg::SCPM_NORMAL;
        end else if (mode_switch) begin
            mode_q <= mode_target;
        end
    end

    // Divider restarts at every switch so the first slow half period is full
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_cnt_q <= scpm_pkg::SLOW_CNT_ZERO;
        end else if (mode_switch) begin
            slow_cnt_q <= scpm_pkg::SLOW_CNT_ZERO;
        end else if (src_edge && (mode_q == scpm_pkg::SCPM_SLOW)) begin
            if (slow_wrap) begin
                slow_cnt_q <= scpm_pkg::SLOW_CNT_ZERO;
            end else begin
                slow_cnt_q <= slow_cnt_q + scpm_pkg::SLOW_CNT_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // Card clock output
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_clk_q <= 1'b0;
        end else if (mode_switch) begin
            card_clk_q <= (mode_target == scpm_pkg::SCPM_NORMAL) ? src_sync : 1'b0;
        end else if (src_edge) begin
            case (mode_q)
                scpm_pkg::SCPM_NORMAL: begin
                    card_clk_q <= src_sync;
                end
                scpm_pkg::SCPM_SLOW: begin
                    if (slow_wrap) begin
                        card_clk_q <= !card_clk_q;
                    end
                end
                scpm_pkg::SCPM_STOPPED: begin
                    card_clk_q <= 1'b0;
                end
                default: begin
                    card_clk_q <= 1'b0;
                end
            endcase
        end
    end

    assign card_clk = card_clk_q;

endmodule // scpm_top

// ### scpm_asserts.sv
module scpm_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [scpm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [scpm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic card_access_pulse,
    input wire logic clock_changed_status
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----
    // Shadow state
    // ----
    logic pend_q;
    logic u_q;
    logic s_q;
    logic hit;
    logic wr;
    logic ok_rd;
    assign hit = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h08;
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign ok_rd = s_axi_rvalid && s_axi_rresp == scpm_pkg::RESP_OKAY;
    always_ff @(posedge aclk) begin
        if (!aresetn) pend_q <= 1'b0;
        else if (card_access_pulse) pend_q <= 1'b1;
        else if (hit) pend_q <= 1'b0;
    end
    // Bench offers address and data together, so one joint handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            u_q <= 1'b0;
            s_q <= 1'b0;
        end else if (wr && s_axi_awaddr[7:2] == 6'h08) begin
            if (s_axi_wstrb[2]) u_q <= s_axi_wdata[16];
            if (s_axi_wstrb[0]) s_q <= s_axi_wdata[0];
        end
    end
    // ----
    // Properties
    // ----
    a_reserved_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hfcfefffe) == 32'h0)
        else $error("reserved bits not zero");
    a_reset_clear: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !clock_changed_status)
        else $error("state not cleared by reset");
    a_access_flag: assert property ($rose(s_axi_rvalid) && ok_rd |-> s_axi_rdata[25] == $past(pend_q))
        else $error("access flag wrong");
    a_mode_mirror: assert property ($rose(s_axi_rvalid) && ok_rd |-> s_axi_rdata[24] == $past(clock_changed_status))
        else $error("mode status mismatch");
    a_stored_bits: assert property ($rose(s_axi_rvalid) && ok_rd |-> s_axi_rdata[16] == $past(u_q) && s_axi_rdata[0] == $past(s_q))
        else $error("writable bits wrong");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] != 6'h08 |=> s_axi_rresp == scpm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_mapped_okay: assert property (hit |=> s_axi_rvalid && s_axi_rresp == scpm_pkg::RESP_OKAY)
        else $error("mapped read refused");
    a_write_answer: assert property (wr |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
endmodule // scpm_asserts

bind scpm_top scpm_asserts chk (.*);

// ### scpm_card.sv
module scpm_card (
    output logic card_clk_src,
    input wire logic card_clk,
    output int rises
);
    timeunit 1ns;
    timeprecision 1ns;
    // Source clock runs free; odd offset keeps it unrelated to aclk
    initial begin
        card_clk_src = 1'b0;
        rises = 0;
        #137;
        forever #400 card_clk_src = ~card_clk_src;
    end
    always @(posedge card_clk) rises++;
endmodule // scpm_card

// ### testbench.sv
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("[FAIL] %s exp %0h got %0h", nm, (e), (g)); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, card_clk_src, socket_idle;
    logic card_access_pulse, card_clk, clock_changed_status, u_m, s_m, acc_m;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
    logic [3:0] s_axi_wstrb, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int rises, num_errors, checks, n0;
    int unsigned seed_v;
    scpm_top dut (.*);
    scpm_card card (.*);
    always #50 aclk = ~aclk;
    function automatic logic [31:0] exp_reg(input logic chg);
        return {6'h00, acc_m, chg, 7'h00, u_m, 15'h0000, s_m};
    endfunction
    // ----
    // Bus and report tasks
    // ----
    task automatic final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            v = s_axi_rdata;
            r = s_axi_rresp;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse;
        card_access_pulse <= 1'b1;
        @(posedge aclk);
        card_access_pulse <= 1'b0;
        @(posedge aclk);
    endtask
    // Counts card clock rises over 512 cycles, then checks status
    task automatic mode(input logic idle, input logic u, input logic sl, input logic chg, input int lo, input int hi);
        int c;
        wrr(8'h20, {15'h0000, u, 15'h0000, sl}, 4'hf, rs);
        u_m = u;
        s_m = sl;
        socket_idle <= idle;
        repeat (40) @(posedge aclk);
        n0 = rises;
        repeat (512) @(posedge aclk);
        c = rises - n0;
        `CHK("rate", 1'b1, (c >= lo && c <= hi))
        `CHK("status_pin", chg, clock_changed_status)
        rdr(8'h20, rd, rs);
        `CHK("status_reg", exp_reg(chg), rd)
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {socket_idle, card_access_pulse, u_m, s_m, acc_m} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
        num_errors = 0;
        checks = 0;
        seed_v = $urandom(32'h7f767736);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(8'h20, rd, rs);
        `CHK("reset", 32'h0, rd)
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            s = 4'($urandom());
            wrr(8'h20, d, s, rs);
            `CHK("bresp", scpm_pkg::RESP_OKAY, rs)
            if (s[2]) u_m = d[16];
            if (s[0]) s_m = d[0];
            acc_m = i[0];
            if (acc_m) pulse();
            rdr(8'h20 | 8'(i % 4), rd, rs);
            `CHK("reg", exp_reg(1'b0), rd)
            acc_m = 1'b0;
            rdr(8'h20, rd, rs);
            `CHK("cleared", exp_reg(1'b0), rd)
        end
        pulse();
        acc_m = 1'b1;
        rdr(8'h24, rd, rs);
        `CHK("unmapped_rd", {scpm_pkg::RESP_SLVERR, 32'h0}, {rs, rd})
        wrr(8'h24, 32'hffffffff, 4'hf, rs);
        `CHK("unmapped_wr", scpm_pkg::RESP_SLVERR, rs)
        rdr(8'h20, rd, rs);
        `CHK("after_unmapped", exp_reg(1'b0), rd)
        acc_m = 1'b0;
        mode(1'b0, 1'b1, 1'b1, 1'b0, 63, 65);
        mode(1'b1, 1'b0, 1'b1, 1'b1, 0, 0);
        mode(1'b1, 1'b1, 1'b0, 1'b1, 0, 0);
        mode(1'b1, 1'b1, 1'b1, 1'b1, 3, 5);
        final_report();
    end
endmodule // testbench
